// ==== rtl/tmds_path_config_registers.sv ====
// Register bank steering the termination, drive and lane path muxes
// How it works
// - Termination bit 0 disconnects lane termination unless auto termination is on, 1 keeps it connected.
// - Bits 0-3 are source A lanes 0-3; bits 4-7 source B lanes 3-0.
// - Equalizer bit 0 selects 6 dB, 1 selects 12 dB, same lane order.
// - Two-bit pre-emphasis for all outputs: 0, 2, 4, 6 dB.
// - One bit turns all output terminations off or on.
// - One bit picks 10 mA or 20 mA drive on all outputs.
// - Source A sign bit 1 swaps positive and negative of the lane.
// - Source B sign bit 1 swaps positive and negative of the lane.
// - With source A chosen, output lane takes A lane its field names.
// - With source B chosen, output lane takes B lane its field names.
// - Lane mapping is host-writable; default is straight through.
// - Auto termination mode keeps every input termination connected.
// - Source select 0 routes source A, 1 routes source B.
// - Both mapping registers reset to identity mapping.
`timescale 1ns/1ps
module tmds_path_config_registers #(
    parameter int LANES = 4
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic [LANES-1:0] first_src_in_pos,
    input wire logic [LANES-1:0] first_src_in_neg,
    input wire logic [LANES-1:0] second_src_in_pos,
    input wire logic [LANES-1:0] second_src_in_neg,
    output logic [LANES-1:0] out_pos,
    output logic [LANES-1:0] out_neg,
    output logic [LANES-1:0] firstSrcTermOn,
    output logic [LANES-1:0] secondSrcTermOn,
    output logic [LANES-1:0] firstSrcEqHigh,
    output logic [LANES-1:0] secondSrcEqHigh,
    output logic [1:0] out_preemph_level,
    output logic out_term_on,
    output logic out_current_sel
);
    typedef struct packed {
        logic [7:0] modes;
        logic [7:0] rxset;
        logic [7:0] term;
        logic [7:0] eq;
        logic [7:0] tx;
        logic [7:0] sign;
        logic [7:0] amap;
        logic [7:0] bmap;
        logic [7:0] rdata;
    } tpc_state_t;

    tpc_state_t state_ff;
    tpc_state_t nxt_state;

    // Address decode shared by the write strikes
    logic hitModes;
    logic hitRxset;
    logic hitTerm;
    logic hitEq;
    logic hitTx;
    logic hitSign;
    logic hitAmap;
    logic hitBmap;

    assign hitModes = (regAddr == tpc_pkg::ADDR_MODES);
    assign hitRxset = (regAddr == tpc_pkg::ADDR_RXSET);
    assign hitTerm = (regAddr == tpc_pkg::ADDR_TERM);
    assign hitEq = (regAddr == tpc_pkg::ADDR_EQ);
    assign hitTx = (regAddr == tpc_pkg::ADDR_TX);
    assign hitSign = (regAddr == tpc_pkg::ADDR_SIGN);
    assign hitAmap = (regAddr == tpc_pkg::ADDR_AMAP);
    assign hitBmap = (regAddr == tpc_pkg::ADDR_BMAP);

    // One write strike per register; unmapped addresses change nothing
    logic wrModes;
    logic wrRxset;
    logic wrTerm;
    logic wrEq;
    logic wrTx;
    logic wrSign;
    logic wrAmap;
    logic wrBmap;

    assign wrModes = regWrite & hitModes;
    assign wrRxset = regWrite & hitRxset;
    assign wrTerm = regWrite & hitTerm;
    assign wrEq = regWrite & hitEq;
    assign wrTx = regWrite & hitTx;
    assign wrSign = regWrite & hitSign;
    assign wrAmap = regWrite & hitAmap;
    assign wrBmap = regWrite & hitBmap;

    always_comb
    begin
        nxt_state = state_ff;
        if (wrModes)
        begin
            nxt_state.modes = regWdata;
        end
        if (wrRxset)
        begin
            nxt_state.rxset = regWdata;
        end
        if (wrTerm)
        begin
            nxt_state.term = regWdata;
        end
        if (wrEq)
        begin
            nxt_state.eq = regWdata;
        end
        if (wrTx)
        begin
            nxt_state.tx = regWdata;
        end
        if (wrSign)
        begin
            nxt_state.sign = regWdata;
        end
        if (wrAmap)
        begin
            nxt_state.amap = regWdata;
        end
        if (wrBmap)
        begin
            nxt_state.bmap = regWdata;
        end
        // Read-back already shows a write made in this cycle
        case (regAddr)
            tpc_pkg::ADDR_MODES: nxt_state.rdata = nxt_state.modes;
            tpc_pkg::ADDR_RXSET: nxt_state.rdata = nxt_state.rxset;
            tpc_pkg::ADDR_TERM: nxt_state.rdata = nxt_state.term;
            tpc_pkg::ADDR_EQ: nxt_state.rdata = nxt_state.eq;
            tpc_pkg::ADDR_TX: nxt_state.rdata = nxt_state.tx;
            tpc_pkg::ADDR_SIGN: nxt_state.rdata = nxt_state.sign;
            tpc_pkg::ADDR_AMAP: nxt_state.rdata = nxt_state.amap;
            tpc_pkg::ADDR_BMAP: nxt_state.rdata = nxt_state.bmap;
            default: nxt_state.rdata = 8'h00;
        endcase
    end

    // Synchronous reset restores the power-up settings
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_ff.modes <= tpc_pkg::RST_MODES;
            state_ff.rxset <= tpc_pkg::RST_RXSET;
            state_ff.term <= tpc_pkg::RST_TERM;
            state_ff.eq <= tpc_pkg::RST_EQ;
            state_ff.tx <= tpc_pkg::RST_TX;
            state_ff.sign <= tpc_pkg::RST_SIGN;
            state_ff.amap <= tpc_pkg::RST_MAP;
            state_ff.bmap <= tpc_pkg::RST_MAP;
            state_ff.rdata <= 8'h00;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign regRdata = state_ff.rdata;

    logic termAuto;
    logic srcB;
    assign termAuto = state_ff.rxset[tpc_pkg::TERM_AUTO_BIT];
    assign srcB = state_ff.modes[tpc_pkg::SRC_SEL_BIT];

    // Transmitter fields are shared by every output lane
    assign out_current_sel = state_ff.tx[tpc_pkg::CUR_BIT];
    assign out_term_on = state_ff.tx[tpc_pkg::OTERM_BIT];
    assign out_preemph_level = state_ff.tx[tpc_pkg::PE_LSB +: 2];

    // Lane buses, mapping and sign bits of the chosen source
    logic [LANES-1:0] srcPos;
    logic [LANES-1:0] srcNeg;
    logic [2*LANES-1:0] srcMap;
    logic [LANES-1:0] srcSign;

    always_comb
    begin
        if (srcB)
        begin
            srcPos = second_src_in_pos;
            srcNeg = second_src_in_neg;
            srcMap = state_ff.bmap[2*LANES-1:0];
            srcSign = state_ff.sign[tpc_pkg::SIGN_B_LSB +: LANES];
        end
        else
        begin
            srcPos = first_src_in_pos;
            srcNeg = first_src_in_neg;
            srcMap = state_ff.amap[2*LANES-1:0];
            srcSign = state_ff.sign[LANES-1:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < LANES; g++)
        begin : gLane
            // Source B lanes sit in reversed bit order
            localparam int MIRROR = 2 * LANES - 1 - g;

            assign firstSrcTermOn[g] =
                termAuto | state_ff.term[g];
            assign secondSrcTermOn[g] =
                termAuto | state_ff.term[MIRROR];
            assign firstSrcEqHigh[g] = state_ff.eq[g];
            assign secondSrcEqHigh[g] = state_ff.eq[MIRROR];

            // The sign bit follows the output lane, after the mapping
            tpc_lane_mux uMux (
                .inPos(srcPos),
                .inNeg(srcNeg),
                .laneSel(srcMap[2*g +: 2]),
                .polarity(srcSign[g]),
                .outPos(out_pos[g]),
                .outNeg(out_neg[g])
            );
        end
    endgenerate
endmodule

// ==== rtl/tpc_pkg.sv ====
// Package for the video path configuration register bank
package tpc_pkg;
    localparam logic [7:0] ADDR_MODES = 8'h00;
    localparam logic [7:0] ADDR_RXSET = 8'h10;
    localparam logic [7:0] ADDR_TERM = 8'h11;
    localparam logic [7:0] ADDR_EQ = 8'h14;
    localparam logic [7:0] ADDR_TX = 8'h20;
    localparam logic [7:0] ADDR_SIGN = 8'h80;
    localparam logic [7:0] ADDR_AMAP = 8'h81;
    localparam logic [7:0] ADDR_BMAP = 8'h82;
    localparam logic [7:0] RST_MODES = 8'h00;
    localparam logic [7:0] RST_RXSET = 8'h01;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_EQ = 8'hff;
    localparam logic [7:0] RST_TX = 8'h03;
    localparam logic [7:0] RST_SIGN = 8'h00;
    localparam logic [7:0] RST_MAP = 8'he4;
    localparam int SRC_SEL_BIT = 0;
    localparam int TERM_AUTO_BIT = 0;
    localparam int CUR_BIT = 0;
    localparam int OTERM_BIT = 1;
    localparam int PE_LSB = 2;
    localparam int SIGN_B_LSB = 4;
endpackage

// ==== rtl/tpc_lane_mux.sv ====
// One output lane: lane select and polarity swap for a chosen source
`timescale 1ns/1ps
module tpc_lane_mux (
    input wire logic [3:0] inPos,
    input wire logic [3:0] inNeg,
    input wire logic [1:0] laneSel,
    input wire logic polarity,
    output logic outPos,
    output logic outNeg
);
    logic p;
    logic n;
    always_comb
    begin
        p = inPos[laneSel];
        n = inNeg[laneSel];
        outPos = polarity ? n : p;
        outNeg = polarity ? p : n;
    end
endmodule

// ==== test/tpc_host.sv ====
// Host model writing the register bank
`timescale 1ns/1ps
module tpc_host (
    input wire logic clk_sys,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata);
    initial {regWrite, regAddr, regWdata} = '0;
    task wr(input logic [7:0] a, d);
        @(posedge clk_sys) #1 {regWrite, regAddr, regWdata} = {1'b1, a, d};
        @(posedge clk_sys) #1 {regWrite, regWdata} = {1'b0, ~d};
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1 regAddr = a;
        @(posedge clk_sys) #1 d = regRdata;
    endtask
endmodule

// ==== test/tpc_chk.sv ====
// Assertions on the register bank ports
`timescale 1ns/1ps
module tpc_chk #(parameter int LANES = 4) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [LANES-1:0] firstSrcEqHigh,
    input wire logic [LANES-1:0] secondSrcEqHigh,
    input wire logic [1:0] out_preemph_level,
    input wire logic out_term_on,
    input wire logic out_current_sel);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire logic txWr = regWrite && regAddr == tpc_pkg::ADDR_TX;
    wire logic eqWr = regWrite && regAddr == tpc_pkg::ADDR_EQ;
    a_pe_load: assert property (txWr |=>
        out_preemph_level == $past(regWdata[3:2])) else $error("pe");
    a_cur_load: assert property (txWr |=>
        out_current_sel == $past(regWdata[0])) else $error("cur");
    a_oterm_load: assert property (txWr |=>
        out_term_on == $past(regWdata[1])) else $error("out term");
    a_tx_hold: assert property (!txWr |=>
        $stable({out_preemph_level, out_current_sel})) else $error("tx");
    a_pe_cause: assert property ($changed(out_preemph_level) |->
        $past(txWr)) else $error("pe cause");
    a_eqa_load: assert property (eqWr |=>
        firstSrcEqHigh == $past(regWdata[3:0])) else $error("eq a");
    a_eqb_order: assert property (eqWr |=>
        secondSrcEqHigh[LANES-1] == $past(regWdata[4])) else $error("eq b");
    a_eq_hold: assert property (!eqWr |=>
        $stable({firstSrcEqHigh, secondSrcEqHigh})) else $error("eq");
    a_eq_cause: assert property ($changed(secondSrcEqHigh) |->
        $past(eqWr)) else $error("eq cause");
endmodule
bind tmds_path_config_registers tpc_chk #(.LANES(LANES)) tpc_chk_inst (.*);

// ==== test/tmds_path_config_registers_bench.sv ====
// Bench for the path configuration register bank
`timescale 1ns/1ps
module tmds_path_config_registers_bench;
    logic clk_sys = 0, resetn = 0, regWrite, out_term_on, out_current_sel;
    logic [7:0] regAddr, regWdata, regRdata, rdv;
    logic [3:0] first_src_in_pos = 4'h1, first_src_in_neg = 4'he;
    logic [3:0] second_src_in_pos = 4'h2, second_src_in_neg = 4'hd;
    logic [3:0] out_pos, out_neg, firstSrcTermOn, secondSrcTermOn;
    logic [3:0] firstSrcEqHigh, secondSrcEqHigh;
    logic [1:0] out_preemph_level;
    wire logic [7:0] txOut =
        {4'h0, out_preemph_level, out_term_on, out_current_sel};
    int n_errors = 0, checks = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    tmds_path_config_registers tmds_path_config_registers_inst (.*);
    tpc_host tpc_host_inst (.*);
    task chk(input string n, input logic [7:0] s, e);
        checks++;
        n_errors += int'(s !== e);
        if (s !== e) $display("wrong value %s expected %h seen %h", n, e, s);
    endtask
    task print_verdict(input int hung);
        n_errors += hung;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) if (++cyc == 3000) print_verdict(1);
    initial
    begin
        #76 resetn = 1;
        chk("reset", {firstSrcTermOn, out_pos}, 8'hf1);
        chk("reset eq", {firstSrcEqHigh, secondSrcEqHigh}, 8'hff);
        chk("reset tx", txOut, 8'h03);
        $display("reset test done");
        for (int c = 0; c < 4; c++) tpc_host_inst.wr(8'h20, 8'(5 * c) ^ 8'h06);
        chk("tx", txOut, 8'h09);
        tpc_host_inst.wr(8'h30, 8'h5a);
        tpc_host_inst.rd(8'h20, rdv);
        chk("read tx", rdv, 8'h09);
        $display("transmitter test done");
        tpc_host_inst.wr(8'h10, 8'h00);
        tpc_host_inst.wr(8'h11, 8'h1e);
        chk("term", {firstSrcTermOn, secondSrcTermOn}, 8'he8);
        tpc_host_inst.wr(8'h10, 8'h01);
        chk("auto term", {firstSrcTermOn, secondSrcTermOn}, 8'hff);
        $display("termination test done");
        tpc_host_inst.wr(8'h14, 8'h17);
        chk("eq", {firstSrcEqHigh, secondSrcEqHigh}, 8'h78);
        tpc_host_inst.wr(8'h14, 8'hff);
        chk("eq high", {firstSrcEqHigh, secondSrcEqHigh}, 8'hff);
        $display("equalizer test done");
        tpc_host_inst.wr(8'h81, 8'h1b);
        tpc_host_inst.wr(8'h80, 8'h11);
        chk("path a", {out_neg, out_pos}, 8'h69);
        tpc_host_inst.rd(8'h81, rdv);
        chk("read map a", rdv, 8'h1b);
        tpc_host_inst.wr(8'h00, 8'h01);
        chk("path b", {out_neg, out_pos}, 8'hc3);
        tpc_host_inst.rd(8'h82, rdv);
        chk("read map b", rdv, 8'he4);
        tpc_host_inst.wr(8'h82, 8'h1b);
        chk("path b map", {out_neg, out_pos}, 8'ha5);
        $display("test settings and routing done");
        print_verdict(0);
    end
endmodule
